// *** hw/ucpc_top.sv ***
`timescale 1ns/1ns
// ==========================================================
// Function
// - Modem-control bit 0 set drives terminal-ready low; clear or reset high.
// - Data-set-ready low means peer ready; its level shows in status.
// - Interrupt pin enabled by control bit 3, only for enabled sources.
// - Sources: line errors, receive data, transmit space, modem changes.
// - After reset each interrupt pin is tri-stated.
// - Bit 3 set: interrupt driven, user output low; clear: released, high.
// - Both user outputs are high right after reset.
// - Read strobe falling edge puts addressed register on the data bus.
// - Write strobe rising edge stores data into addressed, selected register.
// - Reset clears registers, idles outputs, disables serial in and out.
// - Ring input rising edge raises modem interrupt; level shows in status.
// - Modem-control bit 1 set drives request-to-send low; reset high.
// - Request-to-send joins automatic flow only when feature bit 6 set.
// - Loopback disables receive pin and transmit pin, routes data inside.
// - Receive-ready low on trigger or data held; high when empty.
// - Transmit-ready low on trigger space or empty; high full or busy.
// - Reference clock input accepted; buffered copy driven out.
// - Each channel has its own active-low chip select.
// - Data bus bit 0 is the least significant bit.
// - Clear-to-send gates transmit only with feature bit 7; shows status bit 4.
module ucpc_top #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ref_clock_in,
  output logic ref_clock_buffered_out,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b_n,
  input wire logic [ucpc_pkg::UCPC_ADDR_W-1:0] register_select,
  input wire logic [ucpc_pkg::UCPC_DATA_W-1:0] host_data_bus_in,
  output logic [ucpc_pkg::UCPC_DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  input wire logic [1:0] cts_n,
  input wire logic [1:0] dsr_n,
  input wire logic [1:0] ri_n,
  input wire logic [1:0] cd_n,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic [1:0] dtr_n,
  output logic [1:0] rts_n,
  output logic user_output_a,
  output logic user_output_b,
  output logic channel_a_irq,
  output logic channel_b_irq,
  output logic [1:0] irq_oe_n,
  output logic rx_ready_a_n,
  output logic rx_ready_b_n,
  output logic tx_ready_a_n,
  output logic tx_ready_b_n,
  input wire logic [1:0] tx_serial_data,
  input wire logic [1:0] rx_line_error,
  input wire logic [1:0] rx_data_avail,
  input wire logic [1:0] tx_space_avail,
  input wire logic [1:0] rx_trigger_hit,
  input wire logic [1:0] rx_fifo_empty,
  input wire logic [1:0] tx_trigger_space,
  input wire logic [1:0] tx_fifo_empty,
  input wire logic [1:0] tx_fifo_full,
  input wire logic [1:0] rx_room_ok,
  output logic [1:0] receiver_serial_in,
  output logic [1:0] tx_clear_to_send
);
  import ucpc_pkg::*;

  if (SYNC_STAGES < UCPC_SYNC_MIN) begin : g_bad_sync
    $error("SYNC_STAGES below two cannot settle metastability");
  end

  // ========================================================
  // Register read decode
  function automatic logic [7:0] ucpc_read_reg(
    input logic [2:0] off,
    input logic [7:0] modem_control_reg,
    input logic [7:0] interrupt_enable_reg,
    input logic [7:0] enhanced_feature_reg,
    input logic [7:0] modem_status_reg
  );
    logic [7:0] r;
    r = UCPC_REG_RESET;
    case (off)
      UCPC_IER_OFFSET: r = interrupt_enable_reg;
      UCPC_EFR_OFFSET: r = enhanced_feature_reg;
      UCPC_MCR_OFFSET: r = modem_control_reg;
      UCPC_MSR_OFFSET: r = modem_status_reg;
      default: r = UCPC_REG_RESET;
    endcase
    return r;
  endfunction : ucpc_read_reg

  // ========================================================
  // Pin synchronisers
  logic [SYNC_STAGES-1:0][UCPC_PIN_W-1:0] sync_d, sync_q;
  logic [UCPC_PIN_W-1:0] pins_raw, pins_s;

  assign pins_raw = {read_strobe_n, write_strobe_n, chip_select_b_n,
                     chip_select_a_n, register_select, host_data_bus_in,
                     cts_n, dsr_n, ri_n, cd_n, serial_in_b, serial_in_a,
                     ref_clock_in};

  // Plain shift; only the last stage is ever looked at
  always_comb begin
    sync_d = sync_q;
    sync_d[0] = pins_raw;
    for (int i = 1; i < SYNC_STAGES; i++) begin
      sync_d[i] = sync_q[i-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= {SYNC_STAGES{UCPC_PIN_RESET}};
    end else begin
      sync_q <= sync_d;
    end
  end

  assign pins_s = sync_q[SYNC_STAGES-1];

  // ========================================================
  // Host strobe bus
  ucpc_bus_e state_d, state_q;
  logic rd_prev_d, rd_prev_q, wr_prev_d, wr_prev_q;
  logic [2:0] addr_d, addr_q;
  logic [7:0] wdata_d, wdata_q, rdata_d, rdata_q;
  logic [1:0] wcs_d, wcs_q;
  logic oe_n_d, oe_n_q, clk_buf_d, clk_buf_q;
  logic rd_s, wr_s, rd_fall, wr_rise, rd_ch;
  logic [1:0] cs_act, wr_en, msr_rd;
  logic [2:0] addr_s;
  logic [1:0][7:0] mcr_d, mcr_q, ier_d, ier_q;
  logic [1:0][7:0] efr_d, efr_q, msr_d, msr_q;

  assign rd_s = pins_s[UCPC_PIN_RD];
  assign wr_s = pins_s[UCPC_PIN_WR];
  assign cs_act = ~pins_s[UCPC_PIN_CS +: 2];
  assign addr_s = pins_s[UCPC_PIN_ADDR +: 3];
  assign rd_fall = rd_prev_q & ~rd_s;
  assign wr_rise = ~wr_prev_q & wr_s;
  // Channel A wins a read if the host breaks the one-select rule; a write goes to both
  assign rd_ch = ~cs_act[0];
  assign wr_en = (state_q == UCPC_BUS_WRITE && wr_rise) ? wcs_q : 2'h0;
  assign msr_rd = (state_q == UCPC_BUS_IDLE && rd_fall &&
                   addr_s == UCPC_MSR_OFFSET) ?
                  (cs_act[0] ? 2'h1 : {cs_act[1], 1'b0}) : 2'h0;

  // Bus phase, read data and write capture
  always_comb begin
    state_d = state_q;
    rd_prev_d = rd_s;
    wr_prev_d = wr_s;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wcs_d = wcs_q;
    rdata_d = rdata_q;
    oe_n_d = oe_n_q;
    clk_buf_d = pins_s[UCPC_PIN_CLK];
    case (state_q)
      UCPC_BUS_IDLE: begin
        if (rd_fall && |cs_act) begin
          state_d = UCPC_BUS_READ;
          rdata_d = ucpc_read_reg(addr_s, mcr_q[rd_ch], ier_q[rd_ch],
                                  efr_q[rd_ch], msr_q[rd_ch]);
          oe_n_d = 1'b0;
        end else if (!wr_s && |cs_act) begin
          state_d = UCPC_BUS_WRITE;
        end
      end
      UCPC_BUS_READ: begin
        if (rd_s) begin
          state_d = UCPC_BUS_IDLE;
          oe_n_d = 1'b1;
        end
      end
      UCPC_BUS_WRITE: begin
        // Track the bus while low so the rise sees last valid data
        if (!wr_s) begin
          addr_d = addr_s;
          wdata_d = pins_s[UCPC_PIN_DATA +: 8];
          wcs_d = cs_act;
        end
        if (wr_rise) begin
          state_d = UCPC_BUS_IDLE;
        end
      end
      default: begin
        state_d = UCPC_BUS_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= UCPC_BUS_IDLE;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      addr_q <= 3'h0;
      wdata_q <= UCPC_REG_RESET;
      wcs_q <= 2'h0;
      rdata_q <= UCPC_REG_RESET;
      oe_n_q <= 1'b1;
      clk_buf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rd_prev_q <= rd_prev_d;
      wr_prev_q <= wr_prev_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wcs_q <= wcs_d;
      rdata_q <= rdata_d;
      oe_n_q <= oe_n_d;
      clk_buf_q <= clk_buf_d;
    end
  end

  assign host_data_bus_out = rdata_q;
  assign host_data_bus_oe_n = oe_n_q;
  assign ref_clock_buffered_out = clk_buf_q;

  // ========================================================
  // Per-channel registers and modem status
  always_comb begin
    logic [3:0] lvl;
    lvl = 4'h0;
    mcr_d = mcr_q;
    ier_d = ier_q;
    efr_d = efr_q;
    msr_d = msr_q;
    for (int ch = 0; ch < 2; ch++) begin
      if (wr_en[ch]) begin
        case (addr_q)
          UCPC_MCR_OFFSET: mcr_d[ch] = wdata_q;
          UCPC_IER_OFFSET: ier_d[ch] = wdata_q;
          UCPC_EFR_OFFSET: efr_d[ch] = wdata_q;
          default: ;
        endcase
      end
      // Active-high levels: cd, ri, dsr, cts
      lvl = {~pins_s[UCPC_PIN_CD + ch], ~pins_s[UCPC_PIN_RI + ch],
             ~pins_s[UCPC_PIN_DSR + ch], ~pins_s[UCPC_PIN_CTS + ch]};
      // Clear first, then set, so a change during the read survives
      if (msr_rd[ch]) begin
        msr_d[ch][3:0] = 4'h0;
      end
      // Auto clear-to-send owns the transmitter, so no host event
      if (lvl[0] != msr_q[ch][UCPC_MSR_CTS_BIT] &&
          !efr_q[ch][UCPC_EFR_AUTO_CTS_BIT]) begin
        msr_d[ch][UCPC_MSR_D_CTS_BIT] = 1'b1;
      end
      if (lvl[1] != msr_q[ch][UCPC_MSR_DSR_BIT]) begin
        msr_d[ch][UCPC_MSR_D_DSR_BIT] = 1'b1;
      end
      if (msr_q[ch][UCPC_MSR_RI_BIT] && !lvl[2]) begin
        msr_d[ch][UCPC_MSR_TERI_BIT] = 1'b1;
      end
      if (lvl[3] != msr_q[ch][UCPC_MSR_CD_BIT]) begin
        msr_d[ch][UCPC_MSR_D_CD_BIT] = 1'b1;
      end
      msr_d[ch][7:4] = lvl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcr_q <= {2{UCPC_REG_RESET}};
      ier_q <= {2{UCPC_REG_RESET}};
      efr_q <= {2{UCPC_REG_RESET}};
      msr_q <= {2{UCPC_REG_RESET}};
    end else begin
      mcr_q <= mcr_d;
      ier_q <= ier_d;
      efr_q <= efr_d;
      msr_q <= msr_d;
    end
  end

  // ========================================================
  // Two independent channel pin blocks
  logic [1:0] rx_pin_s, ser_out, usr_out, irq_q, rxr_n, txr_n;

  assign rx_pin_s = pins_s[UCPC_PIN_RX +: 2];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    ucpc_channel u_chan (
      .clk(ref_clk),
      .rst_n(rst_n),
      .modem_control_reg(mcr_q[c]),
      .interrupt_enable_reg(ier_q[c]),
      .enhanced_feature_reg(efr_q[c]),
      .msr_delta(msr_q[c][3:0]),
      .cts_active(msr_q[c][UCPC_MSR_CTS_BIT]),
      .serial_in(rx_pin_s[c]),
      .tx_serial_data(tx_serial_data[c]),
      .rx_line_error(rx_line_error[c]),
      .rx_data_avail(rx_data_avail[c]),
      .tx_space_avail(tx_space_avail[c]),
      .rx_trigger_hit(rx_trigger_hit[c]),
      .rx_fifo_empty(rx_fifo_empty[c]),
      .tx_trigger_space(tx_trigger_space[c]),
      .tx_fifo_empty(tx_fifo_empty[c]),
      .tx_fifo_full(tx_fifo_full[c]),
      .rx_room_ok(rx_room_ok[c]),
      .dtr_n(dtr_n[c]),
      .rts_n(rts_n[c]),
      .user_out(usr_out[c]),
      .irq(irq_q[c]),
      .irq_oe_n(irq_oe_n[c]),
      .rx_ready_n(rxr_n[c]),
      .tx_ready_n(txr_n[c]),
      .serial_out(ser_out[c]),
      .receiver_in(receiver_serial_in[c]),
      .tx_clear(tx_clear_to_send[c])
    );
  end

  assign {serial_out_b, serial_out_a} = ser_out;
  assign {user_output_b, user_output_a} = usr_out;
  assign {channel_b_irq, channel_a_irq} = irq_q;
  assign {rx_ready_b_n, rx_ready_a_n} = rxr_n;
  assign {tx_ready_b_n, tx_ready_a_n} = txr_n;

  // ========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_write_commit: assert property (
    (wr_en[0] && addr_q == UCPC_MCR_OFFSET)
      |=> mcr_q[0] == $past(wdata_q))
    else $error("write not stored in control register");
  chk_read_drive: assert property (
    (state_q == UCPC_BUS_IDLE && rd_fall && |cs_act)
      |=> !host_data_bus_oe_n [*1] ##1 1)
    else $error("read did not drive the data bus");
  chk_read_release: assert property (
    (state_q == UCPC_BUS_READ && rd_s) |=> host_data_bus_oe_n)
    else $error("data bus not released after read");
  chk_ring_event: assert property (
    (msr_q[1][UCPC_MSR_RI_BIT] && pins_s[UCPC_PIN_RI + 1])
      |=> msr_q[1][UCPC_MSR_TERI_BIT])
    else $error("ring trailing edge not flagged");
  chk_dsr_level: assert property (
    $fell(pins_s[UCPC_PIN_DSR]) |=> msr_q[0][UCPC_MSR_DSR_BIT])
    else $error("data set ready level not shown");
  cov_msr_read: cover property (|msr_rd ##[1:8] oe_n_q);
  cov_write_b: cover property (wr_en[1]);
endmodule : ucpc_top

// *** hw/ucpc_pkg.sv ***
// ==========================================================
// Shared constants for the dual-channel pin control block
package ucpc_pkg;
  localparam int UCPC_DATA_W = 8;
  localparam int UCPC_ADDR_W = 3;
  localparam int UCPC_SYNC_MIN = 2;

  // ========================================================
  // Register offsets within one channel
  localparam logic [2:0] UCPC_IER_OFFSET = 3'h1;
  localparam logic [2:0] UCPC_EFR_OFFSET = 3'h2;
  localparam logic [2:0] UCPC_MCR_OFFSET = 3'h4;
  localparam logic [2:0] UCPC_MSR_OFFSET = 3'h6;

  // ========================================================
  // Field positions
  localparam int UCPC_MCR_DTR_BIT = 0;
  localparam int UCPC_MCR_RTS_BIT = 1;
  localparam int UCPC_MCR_IRQ_EN_BIT = 3;
  localparam int UCPC_MCR_LOOP_BIT = 4;
  localparam int UCPC_EFR_AUTO_RTS_BIT = 6;
  localparam int UCPC_EFR_AUTO_CTS_BIT = 7;
  localparam int UCPC_MSR_D_CTS_BIT = 0;
  localparam int UCPC_MSR_D_DSR_BIT = 1;
  localparam int UCPC_MSR_TERI_BIT = 2;
  localparam int UCPC_MSR_D_CD_BIT = 3;
  localparam int UCPC_MSR_CTS_BIT = 4;
  localparam int UCPC_MSR_DSR_BIT = 5;
  localparam int UCPC_MSR_RI_BIT = 6;
  localparam int UCPC_MSR_CD_BIT = 7;

  // ========================================================
  // Synchronised pin bundle layout
  localparam int UCPC_PIN_W = 26;
  localparam int UCPC_PIN_RD = 25;
  localparam int UCPC_PIN_WR = 24;
  localparam int UCPC_PIN_CS = 22;
  localparam int UCPC_PIN_ADDR = 19;
  localparam int UCPC_PIN_DATA = 11;
  localparam int UCPC_PIN_CTS = 9;
  localparam int UCPC_PIN_DSR = 7;
  localparam int UCPC_PIN_RI = 5;
  localparam int UCPC_PIN_CD = 3;
  localparam int UCPC_PIN_RX = 1;
  localparam int UCPC_PIN_CLK = 0;

  // ========================================================
  // Reset values
  localparam logic [7:0] UCPC_REG_RESET = 8'h00;
  localparam logic [25:0] UCPC_PIN_RESET = 26'h3C007FE;
  localparam logic [9:0] UCPC_CHAN_OUT_RESET = 10'h3F7;

  // Host strobe bus phases
  typedef enum logic [2:0] {
    UCPC_BUS_IDLE = 3'b001,
    UCPC_BUS_READ = 3'b010,
    UCPC_BUS_WRITE = 3'b100
  } ucpc_bus_e;
endpackage : ucpc_pkg

// *** hw/ucpc_channel.sv ***
`timescale 1ns/1ns
// ==========================================================
// One channel's modem, interrupt, ready and loopback pins
module ucpc_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ucpc_pkg::UCPC_DATA_W-1:0] modem_control_reg,
  input wire logic [ucpc_pkg::UCPC_DATA_W-1:0] interrupt_enable_reg,
  input wire logic [ucpc_pkg::UCPC_DATA_W-1:0] enhanced_feature_reg,
  input wire logic [3:0] msr_delta,
  input wire logic cts_active,
  input wire logic serial_in,
  input wire logic tx_serial_data,
  input wire logic rx_line_error,
  input wire logic rx_data_avail,
  input wire logic tx_space_avail,
  input wire logic rx_trigger_hit,
  input wire logic rx_fifo_empty,
  input wire logic tx_trigger_space,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_full,
  input wire logic rx_room_ok,
  output logic dtr_n,
  output logic rts_n,
  output logic user_out,
  output logic irq,
  output logic irq_oe_n,
  output logic rx_ready_n,
  output logic tx_ready_n,
  output logic serial_out,
  output logic receiver_in,
  output logic tx_clear
);
  import ucpc_pkg::*;

  logic [9:0] out_d, out_q;
  logic [3:0] src;
  logic loop;

  // ========================================================
  // Next pin values
  always_comb begin
    loop = modem_control_reg[UCPC_MCR_LOOP_BIT];
    // Source order matches the enable bits 0..3
    src = {|msr_delta, rx_line_error, tx_space_avail,
           rx_data_avail};
    out_d[0] = ~modem_control_reg[UCPC_MCR_DTR_BIT];
    // Auto mode only ever withholds, never forces, the request
    out_d[1] = ~(modem_control_reg[UCPC_MCR_RTS_BIT] &
                 (~enhanced_feature_reg[UCPC_EFR_AUTO_RTS_BIT] | rx_room_ok));
    out_d[2] = ~modem_control_reg[UCPC_MCR_IRQ_EN_BIT];
    out_d[3] = modem_control_reg[UCPC_MCR_IRQ_EN_BIT] & |(src & interrupt_enable_reg[3:0]);
    out_d[4] = ~modem_control_reg[UCPC_MCR_IRQ_EN_BIT];
    out_d[5] = rx_fifo_empty & ~rx_trigger_hit;
    // Full always wins, so an odd status mix cannot claim space
    out_d[6] = tx_fifo_full |
               ~(tx_trigger_space | tx_fifo_empty);
    out_d[7] = loop | tx_serial_data;
    out_d[8] = loop ? tx_serial_data : serial_in;
    out_d[9] = ~enhanced_feature_reg[UCPC_EFR_AUTO_CTS_BIT] | cts_active;
  end

  // Pin flops; reset puts every pin in its idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= UCPC_CHAN_OUT_RESET;
    end else begin
      out_q <= out_d;
    end
  end

  assign {tx_clear, receiver_in, serial_out, tx_ready_n, rx_ready_n,
          irq_oe_n, irq, user_out, rts_n, dtr_n} = out_q;

  // ========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_dtr_tracks_mcr: assert property (
    modem_control_reg[UCPC_MCR_DTR_BIT] |=> !dtr_n)
    else $error("terminal ready not asserted");
  chk_rts_auto_hold: assert property (
    (enhanced_feature_reg[UCPC_EFR_AUTO_RTS_BIT] && !rx_room_ok) |=> rts_n)
    else $error("auto request not withheld");
  chk_irq_off_state: assert property (
    !modem_control_reg[UCPC_MCR_IRQ_EN_BIT] |=> (irq_oe_n && user_out && !irq))
    else $error("interrupt pin not released");
  chk_irq_cause: assert property (
    $rose(irq) |-> $past(modem_control_reg[UCPC_MCR_IRQ_EN_BIT]) &&
                   $past(|(src & interrupt_enable_reg[3:0])))
    else $error("interrupt without enabled source");
  chk_rx_ready_low: assert property (
    !rx_fifo_empty |=> !rx_ready_n)
    else $error("receive ready high with data held");
  chk_tx_ready_full: assert property (
    tx_fifo_full |=> tx_ready_n)
    else $error("transmit ready low while full");
  chk_loop_route: assert property (
    loop |=> serial_out && (receiver_in == $past(tx_serial_data)))
    else $error("loopback routing wrong");
  chk_cts_gate: assert property (
    (enhanced_feature_reg[UCPC_EFR_AUTO_CTS_BIT] && !cts_active) |=> !tx_clear)
    else $error("transmit allowed without clear to send");
  cov_loopback: cover property (loop ##1 !loop);
endmodule : ucpc_channel

// *** testbench/ucpc_host_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Host strobe bus and modem lines seen from the far side
module ucpc_host_model (
  input wire logic ref_clk,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic chip_select_a_n,
  output logic chip_select_b_n,
  output logic [2:0] register_select,
  output logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_n,
  output logic [1:0] cts_n,
  output logic [1:0] dsr_n,
  output logic [1:0] ri_n,
  output logic [1:0] cd_n
);
  // Idle bus, modem lines inactive
  initial begin
    {read_strobe_n, write_strobe_n} = 2'h3;
    {chip_select_a_n, chip_select_b_n} = 2'h3;
    register_select = 3'h0;
    host_data_bus_in = 8'h00;
    {cd_n, ri_n, dsr_n, cts_n} = 8'hFF;
  end

  // All changes land a fixed delay after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : step

  // One access; strobe held 5 cycles so synchronisers see it
  task automatic access(input logic ch, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    step(1);
    chip_select_a_n = ch;
    chip_select_b_n = !ch;
    register_select = a;
    host_data_bus_in = d;
    step(3);
    if (wr) begin
      write_strobe_n = 1'b0;
    end else begin
      read_strobe_n = 1'b0;
    end
    step(5);
    q = host_data_bus_oe_n ? 8'hXX : host_data_bus_out;
    {read_strobe_n, write_strobe_n} = 2'h3;
    step(1);
    // Released data shows the inverse, never a stale match
    host_data_bus_in = ~d;
    chip_select_a_n = 1'b1;
    chip_select_b_n = 1'b1;
    step(8);
  endtask : access

  // Modem lines packed as cd, ri, dsr, cts pairs
  task automatic modem(input logic [7:0] v);
    {cd_n, ri_n, dsr_n, cts_n} = v;
  endtask : modem
endmodule : ucpc_host_model

// *** testbench/ucpc_top_bench.sv ***
`timescale 1ns/1ns
// ==========================================================
// Random register and pin traffic against a reference model
module ucpc_top_bench;
  import ucpc_pkg::*;
  logic ref_clk, rst_n, ref_clock_in;
  logic serial_in_a, serial_in_b;
  logic [1:0] tx_serial_data, rx_line_error, rx_data_avail;
  logic [1:0] tx_space_avail, rx_trigger_hit, rx_fifo_empty;
  logic [1:0] tx_trigger_space, tx_fifo_empty, tx_fifo_full, rx_room_ok;
  logic read_strobe_n, write_strobe_n, chip_select_a_n, chip_select_b_n;
  logic [2:0] register_select;
  logic [7:0] host_data_bus_in, host_data_bus_out;
  logic [1:0] cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, irq_oe_n;
  logic [1:0] receiver_serial_in, tx_clear_to_send;
  logic ref_clock_buffered_out, host_data_bus_oe_n;
  logic serial_out_a, serial_out_b, user_output_a, user_output_b;
  logic channel_a_irq, channel_b_irq, rx_ready_a_n, rx_ready_b_n;
  logic tx_ready_a_n, tx_ready_b_n;
  wire logic [1:0] uo = {user_output_b, user_output_a};
  wire logic [1:0] irq = {channel_b_irq, channel_a_irq};
  wire logic [1:0] rr = {rx_ready_b_n, rx_ready_a_n};
  wire logic [1:0] tr = {tx_ready_b_n, tx_ready_a_n};
  wire logic [1:0] so = {serial_out_b, serial_out_a};
  wire logic [1:0] si = {serial_in_b, serial_in_a};
  int modem_control_reg[2], enhanced_feature_reg[2], interrupt_enable_reg[2], err_count, n_checks;
  logic [31:0] seed = 32'h5A;

  ucpc_top #(.SYNC_STAGES(2)) dut (.ref_clk, .rst_n, .ref_clock_in,
    .ref_clock_buffered_out, .read_strobe_n, .write_strobe_n,
    .chip_select_a_n, .chip_select_b_n, .register_select,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n, .cts_n,
    .dsr_n, .ri_n, .cd_n, .serial_in_a, .serial_in_b, .serial_out_a,
    .serial_out_b, .dtr_n, .rts_n, .user_output_a, .user_output_b,
    .channel_a_irq, .channel_b_irq, .irq_oe_n, .rx_ready_a_n,
    .rx_ready_b_n, .tx_ready_a_n, .tx_ready_b_n, .tx_serial_data,
    .rx_line_error, .rx_data_avail, .tx_space_avail, .rx_trigger_hit,
    .rx_fifo_empty, .tx_trigger_space, .tx_fifo_empty, .tx_fifo_full,
    .rx_room_ok, .receiver_serial_in, .tx_clear_to_send);

  ucpc_host_model hm (.ref_clk, .read_strobe_n, .write_strobe_n,
    .chip_select_a_n, .chip_select_b_n, .register_select,
    .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n, .cts_n,
    .dsr_n, .ri_n, .cd_n);

  // ========================================================
  // Clock and helpers
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Every pin of both channels against the model
  task automatic pins();
    logic [7:0] m, e;
    for (int c = 0; c < 2; c++) begin
      m = modem_control_reg[c][7:0];
      e = enhanced_feature_reg[c][7:0];
      chk(dtr_n[c], !m[0]);
      chk(rts_n[c], !(m[1] && (!e[6] || rx_room_ok[c])));
      chk({uo[c], irq_oe_n[c]}, {2{!m[3]}});
      chk(irq[c], m[3] && |(interrupt_enable_reg[c][2:0] & {rx_line_error[c],
        tx_space_avail[c], rx_data_avail[c]}));
      chk(so[c], m[4] | tx_serial_data[c]);
      chk(receiver_serial_in[c], m[4] ? tx_serial_data[c] : si[c]);
      chk(tx_clear_to_send[c], !e[7] | !cts_n[c]);
      chk(rr[c], !rx_trigger_hit[c] & rx_fifo_empty[c]);
      chk(tr[c], tx_fifo_full[c] |
        !(tx_trigger_space[c] | tx_fifo_empty[c]));
    end
  endtask : pins

  // Random status and serial levels; FIFO flags kept self-consistent
  task automatic drive_pins();
    logic [31:0] r;
    r = rnd();
    rx_fifo_empty = r[1:0];
    rx_data_avail = ~r[1:0];
    rx_trigger_hit = r[3:2] & ~r[1:0];
    tx_fifo_empty = r[5:4];
    tx_fifo_full = r[7:6] & ~r[5:4];
    tx_trigger_space = r[9:8] & ~tx_fifo_full;
    rx_line_error = r[11:10];
    tx_space_avail = r[13:12];
    tx_serial_data = r[15:14];
    rx_room_ok = r[17:16];
    {serial_in_b, serial_in_a} = r[19:18];
    hm.modem(r[27:20]);
  endtask : drive_pins

  // Reset mid-run too: outputs idle at once, registers cleared
  task automatic do_reset();
    rst_n = 1'b0;
    hm.step(2);
    chk({dtr_n, rts_n, irq_oe_n, host_data_bus_oe_n}, 7'h7F);
    chk({uo, irq, rr, tr, so}, 10'h33F);
    // Fresh random inputs, so the post-reset compare is not trivial
    drive_pins();
    rst_n = 1'b1;
    modem_control_reg = '{0, 0};
    enhanced_feature_reg = '{0, 0};
    interrupt_enable_reg = '{0, 0};
    hm.step(4);
    pins();
  endtask : do_reset

  // ========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] q;
    int c;
    ref_clock_in = 1'b0;
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      drive_pins();
      r = rnd();
      c = r[31];
      modem_control_reg[c] = r[7:0];
      interrupt_enable_reg[c] = r[10:8];
      enhanced_feature_reg[c] = r[23:16];
      hm.access(c[0], 1'b1, UCPC_MCR_OFFSET, modem_control_reg[c][7:0], q);
      hm.access(c[0], 1'b1, UCPC_EFR_OFFSET, enhanced_feature_reg[c][7:0], q);
      hm.access(c[0], 1'b1, UCPC_IER_OFFSET, interrupt_enable_reg[c][7:0], q);
      hm.access(c[0], 1'b0, UCPC_MCR_OFFSET, 8'h00, q);
      chk(q, modem_control_reg[c][7:0]);
      hm.access(c[0], 1'b0, UCPC_MSR_OFFSET, 8'h00, q);
      chk(q[7:4], {cd_n[c], ri_n[c], dsr_n[c], cts_n[c]} ^ 4'hF);
      hm.access(c[0], 1'b0, 3'h0, 8'h00, q);
      chk(q, 8'h00);
      pins();
    end
    $display("test random traffic done");
    // Only the modem source is enabled; other status stays random
    hm.access(1'b0, 1'b1, UCPC_IER_OFFSET, 8'h08, q);
    hm.access(1'b0, 1'b1, UCPC_MCR_OFFSET, 8'h08, q);
    hm.modem(8'hEF);
    hm.step(6);
    hm.access(1'b0, 1'b0, UCPC_MSR_OFFSET, 8'h00, q);
    chk(channel_a_irq, 1'b0);
    hm.modem(8'hFF);
    hm.step(6);
    chk(channel_a_irq, 1'b1);
    hm.access(1'b0, 1'b0, UCPC_MSR_OFFSET, 8'h00, q);
    chk({q[6], q[2], channel_a_irq}, 3'h2);
    $display("test ring done");
    do_reset();
    ref_clock_in = 1'b1;
    hm.step(5);
    chk(ref_clock_buffered_out, 1'b1);
    ref_clock_in = 1'b0;
    hm.step(5);
    chk(ref_clock_buffered_out, 1'b0);
    $display("test reset again and clock done");
    print_verdict();
  end

  // Hang guard, about fourteen times the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
endmodule : ucpc_top_bench
